// ### design/ihc_top.sv
// ide host channel config, status, threshold and bus-master register block
// assumes register ports and channel event inputs synchronous to core_clk_in

////////////////////////////////////////////////////////////////////////////////
module ihc_fifo #(
  parameter int W  = 16,
  parameter int D  = 8,
  parameter int AW = 3
) (
  input  wire logic         clk_in,    // clock
  input  wire logic         rstn_in,   // sync reset, low
  input  wire logic         flush_in,  // discard contents
  input  wire logic [W-1:0] wdata_in,  // write data
  input  wire logic         wvalid_in, // write valid
  output logic              wready_out, // write ready
  output logic [W-1:0]      rdata_out, // read data
  output logic              rvalid_out, // read valid
  input  wire logic         rready_in, // read ready
  output logic [AW:0]       count_out  // fill level
);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  wire           do_w = wvalid_in && wready_out;
  wire           do_r = rvalid_out && rready_in;

  assign wready_out = (cnt_r != (AW+1)'(D)) && !flush_in;
  assign rvalid_out = (cnt_r != '0);
  assign rdata_out  = mem_r[rp_r];
  assign count_out  = cnt_r;

  always_ff @(posedge clk_in) begin
    if (do_w) begin
      mem_r[wp_r] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in || flush_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_r + AW'(do_w);
      rp_r  <= rp_r + AW'(do_r);
      cnt_r <= cnt_r + (AW+1)'(do_w) - (AW+1)'(do_r);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module ihc_top
  import ihc_pkg::*;
(
  input  wire logic        core_clk_in,      // 10 MHz core clock
  input  wire logic        rstn_in,          // sync reset, low
  input  wire logic        cfg_wr_in,        // config byte write strobe
  input  wire logic        cfg_rd_in,        // config byte read strobe
  input  wire logic [7:0]  cfg_addr_in,      // config byte offset
  input  wire logic [7:0]  cfg_wdata_in,     // config write data
  output logic      [7:0]  cfg_rdata_out,    // config read data
  input  wire logic        io_wr_in,         // i/o byte write strobe
  input  wire logic        io_rd_in,         // i/o byte read strobe
  input  wire logic [31:0] io_addr_in,       // i/o byte address
  input  wire logic [7:0]  io_wdata_in,      // i/o write data
  output logic      [7:0]  io_rdata_out,     // i/o read data
  output logic             io_hit_out,       // address in bus-master block
  input  wire logic [7:0]  pri_stat_set_in,  // primary status set events
  input  wire logic [7:0]  sec_stat_set_in,  // secondary status set events
  input  wire logic        pio_rd_req_in,    // pio read prefetch requested
  input  wire logic        pio_wr_busy_in,   // posted write in progress
  input  wire logic        dma_rd_busy_in,   // dma read active
  input  wire logic        dma_wr_busy_in,   // dma write active
  input  wire logic        bm_busy_in,       // bus-master op outstanding
  input  wire logic        drq_in,           // drive dma request
  input  wire logic        irq_raw_in,       // channel interrupt from drive
  input  wire logic        dir_m2d_in,       // 1 memory-to-drive transfer
  input  wire logic [15:0] fifo_wdata_in,    // data into fifo
  input  wire logic        fifo_wvalid_in,   // fifo write valid
  output logic             fifo_wready_out,  // fifo write ready
  output logic      [15:0] fifo_rdata_out,   // data out of fifo
  output logic             fifo_rvalid_out,  // fifo read valid
  input  wire logic        fifo_rready_in,   // fifo read ready
  input  wire logic        fifo_flush_in,    // discard fifo contents
  output logic             flush_now_out,    // fill reached threshold
  output logic             pf_run_out,       // prefetch may fetch
  input  wire logic        pf_byte_in,       // one prefetch byte fetched
  output logic             irq_out,          // gated interrupt
  input  wire logic        iobase_rst_in,    // request to reset i/o base
  output logic             cg33_en_out,      // 1 gate 33 MHz clock
  output logic             cgfifo_en_out,    // 1 gate fifo 133/100 clock
  output logic             cgch133_en_out,   // 1 gate channel 133/100 clock
  output logic             cgch66_en_out     // 1 gate channel 66 clock
);
  logic [31:0] bar_r;
  logic [1:0]  thr_dm_r;
  logic        pf_cnt_en_r;
  logic [7:0]  clkgate_r;
  logic [11:0] sect_r;
  logic        irqgate_r;
  logic [7:0]  thrctl_r;
  logic [7:0]  pcmd_r;
  logic [7:0]  scmd_r;
  logic [7:0]  pstat_r;
  logic [7:0]  sstat_r;
  logic [31:0] pptr_r;
  logic [31:0] sptr_r;
  logic [11:0] pf_cnt_r;
  logic [3:0]  fifo_cnt;
  logic [7:0]  chstat;

  ////////////////////////////////////////////////////////////////////////////
  // fifo in the data path
  ihc_fifo #(.W(FIFO_W), .D(FIFO_D), .AW(FIFO_AW)) u_fifo (
    .clk_in     (core_clk_in),
    .rstn_in    (rstn_in),
    .flush_in   (fifo_flush_in),
    .wdata_in   (fifo_wdata_in),
    .wvalid_in  (fifo_wvalid_in),
    .wready_out (fifo_wready_out),
    .rdata_out  (fifo_rdata_out),
    .rvalid_out (fifo_rvalid_out),
    .rready_in  (fifo_rready_in),
    .count_out  (fifo_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire        fifo_empty = (fifo_cnt == '0);
  wire [31:0] io_off     = io_addr_in - {bar_r[31:4], 4'h0};
  assign      io_hit_out = (io_addr_in[31:4] == bar_r[31:4]);
  wire [3:0]  io_idx     = io_off[3:0];
  wire        io_we      = io_wr_in && io_hit_out;
  wire        io_ptr_p   = (io_idx[3:2] == IO_PPTR[3:2]);
  wire        io_ptr_s   = (io_idx[3:2] == IO_SPTR[3:2]);
  wire        bar_sel    = (cfg_addr_in[7:2] == CFG_BAR0[7:2]);
  wire        two_thr    = thrctl_r[TC_TWO_BIT];
  wire [1:0]  thr_m2d    = thrctl_r[3:2];
  // direction chooses the field only when two thresholds are on
  wire [1:0]  thr_sel    = (two_thr && dir_m2d_in) ? thr_m2d : thr_dm_r;
  // 00 quarter 01 half 10 three quarters 11 full
  wire [3:0]  thr_lvl    = {2'b00, thr_sel} * 4'h2 + 4'h2;
  assign flush_now_out   = (fifo_cnt >= thr_lvl);
  assign pf_run_out      = pio_rd_req_in && fifo_wready_out &&
                           (!pf_cnt_en_r || (pf_cnt_r != '0));
  // hold the interrupt while data remains when gating is on
  assign irq_out         = irq_raw_in && (!irqgate_r || fifo_empty);
  assign cg33_en_out     = !clkgate_r[CG_33_BIT];
  assign cgfifo_en_out   = !clkgate_r[CG_FIFO_BIT];
  assign cgch133_en_out  = !clkgate_r[CG_CH133_BIT];
  assign cgch66_en_out   = !clkgate_r[CG_CH66_BIT];
  assign chstat = {irq_out, pio_rd_req_in, pio_wr_busy_in,
                   dma_rd_busy_in, dma_wr_busy_in,
                   bm_busy_in, fifo_empty, drq_in};

  ////////////////////////////////////////////////////////////////////////////
  // config space
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      thr_dm_r    <= THR_RST;
      pf_cnt_en_r <= 1'b0;
      clkgate_r   <= CLKGATE_RST;
      sect_r      <= SECT_RST;
      irqgate_r   <= IRQGATE_RST;
      thrctl_r    <= THRCTL_RST;
    end else if (cfg_wr_in) begin
      unique case (cfg_addr_in)
        CFG_THR_DM:  thr_dm_r    <= cfg_wdata_in[1:0];
        CFG_PF_OPT:  pf_cnt_en_r <= cfg_wdata_in[PF_CNT_BIT];
        CFG_CLKGATE: clkgate_r   <= cfg_wdata_in & CLKGATE_MASK;
        CFG_SECT_LO: sect_r[7:0] <= cfg_wdata_in;
        CFG_SECT_HI: sect_r[11:8] <= cfg_wdata_in[3:0];
        CFG_IRQGATE: irqgate_r   <= cfg_wdata_in[0];
        CFG_THRCTL:  thrctl_r    <= cfg_wdata_in & THRCTL_MASK;
        default: ;
      endcase
    end
  end

  // base register cleared on request only while enabled
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      bar_r <= BAR_RST;
    end else if (iobase_rst_in && thrctl_r[TC_IOBRST_BIT]) begin
      bar_r <= BAR_RST;
    end else if (cfg_wr_in && bar_sel) begin
      unique case (cfg_addr_in[1:0])
        2'h0: bar_r[7:4]   <= cfg_wdata_in[7:4];
        2'h1: bar_r[15:8]  <= cfg_wdata_in;
        2'h2: bar_r[23:16] <= cfg_wdata_in;
        2'h3: bar_r[31:24] <= cfg_wdata_in;
      endcase
    end
  end

  // prefetch byte counter reloads when no prefetch is requested
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in || !pio_rd_req_in) begin
      pf_cnt_r <= sect_r;
    end else if (pf_byte_in && pf_cnt_r != '0) begin
      pf_cnt_r <= pf_cnt_r - 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus-master i/o space
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      pcmd_r <= '0;
      scmd_r <= '0;
      pptr_r <= '0;
      sptr_r <= '0;
    end else if (io_we) begin
      if (io_idx == IO_PCMD) pcmd_r <= io_wdata_in;
      if (io_idx == IO_SCMD) scmd_r <= io_wdata_in;
      if (io_ptr_p) pptr_r[8*io_idx[1:0] +: 8] <= io_wdata_in;
      if (io_ptr_s) sptr_r[8*io_idx[1:0] +: 8] <= io_wdata_in;
    end
  end

  // set wins over a same-cycle write-one clear
  wire [7:0] pclr = (io_we && io_idx == IO_PSTAT) ? io_wdata_in : 8'h00;
  wire [7:0] sclr = (io_we && io_idx == IO_SSTAT) ? io_wdata_in : 8'h00;
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      pstat_r <= '0;
      sstat_r <= '0;
    end else begin
      pstat_r <= (pstat_r & ~pclr) | pri_stat_set_in;
      sstat_r <= (sstat_r & ~sclr) | sec_stat_set_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data
  logic [7:0] cfg_rd_nxt;
  logic [7:0] io_rd_nxt;
  always_comb begin
    unique case (cfg_addr_in)
      8'h20, 8'h21, 8'h22, 8'h23: cfg_rd_nxt = bar_r[8*cfg_addr_in[1:0] +: 8];
      CFG_THR_DM:  cfg_rd_nxt = {6'h00, thr_dm_r};
      CFG_PF_OPT:  cfg_rd_nxt = {3'h0, pf_cnt_en_r, 4'h0};
      CFG_CLKGATE: cfg_rd_nxt = clkgate_r;
      CFG_SECT_LO: cfg_rd_nxt = sect_r[7:0];
      CFG_SECT_HI: cfg_rd_nxt = {4'h0, sect_r[11:8]};
      CFG_CHSTAT:  cfg_rd_nxt = chstat;
      CFG_IRQGATE: cfg_rd_nxt = {7'h00, irqgate_r};
      CFG_THRCTL:  cfg_rd_nxt = thrctl_r;
      default:     cfg_rd_nxt = 8'h00;
    endcase
  end
  always_comb begin
    io_rd_nxt = 8'h00;
    if (io_idx == IO_PCMD) io_rd_nxt = pcmd_r;
    if (io_idx == IO_PSTAT) io_rd_nxt = pstat_r;
    if (io_idx == IO_SCMD) io_rd_nxt = scmd_r;
    if (io_idx == IO_SSTAT) io_rd_nxt = sstat_r;
    if (io_ptr_p) io_rd_nxt = pptr_r[8*io_idx[1:0] +: 8];
    if (io_ptr_s) io_rd_nxt = sptr_r[8*io_idx[1:0] +: 8];
    if (!io_hit_out) io_rd_nxt = 8'h00;
  end
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      cfg_rdata_out <= '0;
      io_rdata_out  <= '0;
    end else begin
      if (cfg_rd_in) cfg_rdata_out <= cfg_rd_nxt;
      if (io_rd_in) io_rdata_out <= io_rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_irq_gate: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    irqgate_r && !fifo_empty |-> !irq_out) else $error("irq passed unflushed fifo");
  chk_irq_pass: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !irqgate_r && irq_raw_in |-> irq_out) else $error("irq not passed");
  chk_empty_flag: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    chstat[1] == (fifo_cnt == 4'h0)) else $error("empty flag wrong");
  // a status write, then the cycle in which its clear shows
  sequence seq_pstat_w1c;
    io_we && io_idx == IO_PSTAT ##1 1'b1;
  endsequence
  sequence seq_clkgate_wr;
    cfg_wr_in && cfg_addr_in == CFG_CLKGATE;
  endsequence
  chk_w1c_clear: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    seq_pstat_w1c |-> ((pstat_r & $past(io_wdata_in))
      == $past(pri_stat_set_in & io_wdata_in))) else $error("status not cleared");
  chk_w1c_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $past(sstat_r) != 8'h00 |-> ((sstat_r | $past(sclr)) & $past(sstat_r))
      == $past(sstat_r)) else $error("status bit lost");
  chk_thr_single: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !two_thr |-> thr_sel == thr_dm_r) else $error("single threshold not used");
  chk_thr_two: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    two_thr && dir_m2d_in |-> thr_sel == thrctl_r[3:2]) else $error("m2d threshold");
  chk_flush_full: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    thr_sel == 2'h3 && fifo_cnt < FIFO_FULL |-> !flush_now_out) else $error("early flush");
  chk_cmd_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    io_we && io_idx == IO_SCMD |=> scmd_r == $past(io_wdata_in)) else $error("cmd write");
  chk_pf_stop: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    pf_cnt_en_r && pf_cnt_r == 12'h000 |-> !pf_run_out) else $error("prefetch overran");
  chk_clk33: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    seq_clkgate_wr |=> cg33_en_out == !$past(cfg_wdata_in[CG_33_BIT]))
    else $error("33 clock gate does not follow its bit");
endmodule

// ### include/ihc_pkg.sv
// constants for the ide host channel configuration and bus-master register block
// assumes byte-wide config and i/o register ports synchronous to core_clk_in
//
// Notes on behaviour
// - 33 MHz channel clock gated when its control bit is 0, running when 1.
// - fifo and channel 133/100 and 66 MHz domains gated when bit is 0.
// - 12-bit writable prefetch sector size, reset 512 bytes, upper four bits zero.
// - read-only flags for pio read prefetch and posted write in progress.
// - read-only flags for dma read and dma write in progress.
// - bus-master complete flag inverted: 0 complete, 1 outstanding.
// - read-only flag set while the drive has a dma request pending.
// - interrupt gating (reset 1) holds irq until the data fifo is flushed.
// - control bit, default 1, enabling the reset of the i/o base address.
// - two-threshold option clear: one threshold field serves both directions.
// - two-threshold option set: separate memory-to-drive threshold, default half.
// - bus-master i/o block decoded relative to 32-bit base at config 20h-23h.
// - 8-bit command registers per channel at i/o 00h and 08h, reset zero.
// - primary bus-master status at i/o 02h, write one clears, zero leaves.
// - secondary bus-master status at i/o 0ah, same clearing and zero reset.
// - 32-bit descriptor table pointers at i/o 04h-07h and 0ch-0fh, reset zero.
// - threshold encodings quarter, half, three-quarters, full; full not for udma reads.
// - byte-counter option stops prefetch at sector size, else prefetch while fifo space.
package ihc_pkg;
  localparam logic [7:0]  CFG_BAR0      = 8'h20;
  localparam logic [7:0]  CFG_THR_DM    = 8'hc3;
  localparam logic [7:0]  CFG_PF_OPT    = 8'hc4;
  localparam logic [7:0]  CFG_CLKGATE   = 8'hd5;
  localparam logic [7:0]  CFG_SECT_LO   = 8'he0;
  localparam logic [7:0]  CFG_SECT_HI   = 8'he1;
  localparam logic [7:0]  CFG_CHSTAT    = 8'hf0;
  localparam logic [7:0]  CFG_IRQGATE   = 8'hf1;
  localparam logic [7:0]  CFG_THRCTL    = 8'hf2;
  localparam logic [3:0]  IO_PCMD       = 4'h0;
  localparam logic [3:0]  IO_PSTAT      = 4'h2;
  localparam logic [3:0]  IO_PPTR       = 4'h4;
  localparam logic [3:0]  IO_SCMD       = 4'h8;
  localparam logic [3:0]  IO_SSTAT      = 4'ha;
  localparam logic [3:0]  IO_SPTR       = 4'hc;
  localparam logic [11:0] SECT_RST      = 12'h200;
  localparam logic [1:0]  THR_RST       = 2'h1;
  localparam logic [7:0]  CLKGATE_RST   = 8'h00;
  localparam logic [7:0]  CLKGATE_MASK  = 8'h1b;
  localparam logic [7:0]  THRCTL_MASK   = 8'h3c;
  localparam logic [7:0]  THRCTL_RST    = 8'h24;
  localparam logic [31:0] BAR_RST       = 32'h0000_0001;
  localparam logic        IRQGATE_RST   = 1'b1;
  localparam int          CG_33_BIT     = 4;
  localparam int          CG_FIFO_BIT   = 3;
  localparam int          CG_CH133_BIT  = 1;
  localparam int          CG_CH66_BIT   = 0;
  localparam int          TC_IOBRST_BIT = 5;
  localparam int          TC_TWO_BIT    = 4;
  localparam int          PF_CNT_BIT    = 4;
  localparam int          FIFO_W        = 16;
  localparam int          FIFO_D        = 8;
  localparam int          FIFO_AW       = 3;
  localparam logic [3:0]  FIFO_FULL     = 4'h8;
endpackage

// ### tb/ihc_drive_model.sv
// drive-side model: raises a dma request and pushes a burst of words into the fifo
// assumes the fifo write handshake and core clock of ihc_top
module ihc_drive_model (
  input  wire logic        clk_in,     // core clock
  input  wire logic        rstn_in,    // sync reset, low
  input  wire logic        go_in,      // start a burst
  input  wire logic [3:0]  n_in,       // words in burst
  input  wire logic        slow_in,    // idle cycle after each word
  input  wire logic        irq_req_in, // raise drive interrupt
  input  wire logic        wready_in,  // fifo accepts
  output logic             drq_out,    // dma request pending
  output logic             irq_out,    // drive interrupt level
  output logic      [15:0] wdata_out,  // word to fifo
  output logic             wvalid_out  // word valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left_r;
  logic [7:0] seq_r;
  logic       gap_r;
  ////////////////////////////////////////////////////////////////////////////////
  assign drq_out    = (left_r != 4'h0);
  assign wvalid_out = drq_out & ~gap_r;
  // released data bus shows the inverse, never the last word
  assign wdata_out  = wvalid_out ? {8'hd0, seq_r} : ~{8'hd0, seq_r};
  always_ff @(posedge clk_in) begin
    irq_out <= rstn_in & irq_req_in;
    gap_r   <= rstn_in & slow_in & wvalid_out & wready_in;
    if (!rstn_in) begin
      left_r <= 4'h0;
      seq_r  <= 8'h00;
    end else if (go_in) begin
      left_r <= n_in;
    end else if (wvalid_out && wready_in) begin
      left_r <= left_r - 4'h1;
      seq_r  <= seq_r + 8'h01;
    end
  end
endmodule

// ### tb/tb_top.sv
// self-checking bench: config and i/o register accesses, fifo, thresholds, irq gating
// assumes ihc_pkg, ihc_top and ihc_drive_model compiled before it
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD %0t value %h expected %h", $time, (a), (e)); end end
module tb_top
  import ihc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rstn = 0, cfg_wr = 0, cfg_rd = 0, io_wr = 0, io_rd = 0;
  logic [7:0]  cfg_addr = 0, wd = 0, cfg_rdata, io_rdata, pset = 0, sset = 0;
  logic [31:0] io_addr = 0, base = 32'h0000c000;
  logic [4:0]  lv = 0;
  logic [3:0]  n_push = 0;
  logic [15:0] wdata, rdata;
  logic        dir_m2d = 0, rready = 0, flush = 0, pf_byte = 0, iob_rst = 0, irq_req = 0;
  logic        go = 0, slow = 0, drq, irq_raw, wvalid, wready, rvalid, flush_now, pf_run;
  logic        io_hit, irq, cg33, cgf, cg133, cg66;
  int          n_mismatch = 0, num_checks = 0, sent = 0, first;
  logic [3:0]  offs [10] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hc, 4'hd, 4'he, 4'hf};

  ////////////////////////////////////////////////////////////////////////////////
  ihc_top DUT (.core_clk_in(clk), .rstn_in(rstn), .cfg_wr_in(cfg_wr), .cfg_rd_in(cfg_rd),
    .cfg_addr_in(cfg_addr), .cfg_wdata_in(wd), .cfg_rdata_out(cfg_rdata), .io_wr_in(io_wr),
    .io_rd_in(io_rd), .io_addr_in(io_addr), .io_wdata_in(wd), .io_rdata_out(io_rdata),
    .io_hit_out(io_hit), .pri_stat_set_in(pset), .sec_stat_set_in(sset),
    .pio_rd_req_in(lv[4]), .pio_wr_busy_in(lv[3]), .dma_rd_busy_in(lv[2]),
    .dma_wr_busy_in(lv[1]), .bm_busy_in(lv[0]), .drq_in(drq), .irq_raw_in(irq_raw),
    .dir_m2d_in(dir_m2d), .fifo_wdata_in(wdata), .fifo_wvalid_in(wvalid),
    .fifo_wready_out(wready), .fifo_rdata_out(rdata), .fifo_rvalid_out(rvalid),
    .fifo_rready_in(rready), .fifo_flush_in(flush), .flush_now_out(flush_now),
    .pf_run_out(pf_run), .pf_byte_in(pf_byte), .irq_out(irq), .iobase_rst_in(iob_rst),
    .cg33_en_out(cg33), .cgfifo_en_out(cgf), .cgch133_en_out(cg133), .cgch66_en_out(cg66));
  ihc_drive_model drive (.clk_in(clk), .rstn_in(rstn), .go_in(go), .n_in(n_push),
    .slow_in(slow), .irq_req_in(irq_req), .wready_in(wready), .drq_out(drq),
    .irq_out(irq_raw), .wdata_out(wdata), .wvalid_out(wvalid));

  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one byte access; a read compares against v
  task automatic acc(input bit io, input bit wr, input logic [31:0] a, input logic [7:0] v);
    @(posedge clk);
    if (io) {io_wr, io_rd} <= {wr, !wr};
    else {cfg_wr, cfg_rd} <= {wr, !wr};
    io_addr  <= a;
    cfg_addr <= a[7:0];
    wd       <= v;
    @(posedge clk);
    {io_wr, io_rd, cfg_wr, cfg_rd} <= 4'h0;
    #1 if (!wr) `CHK(io ? io_rdata : cfg_rdata, v)
  endtask
  task automatic strobe(input int which);
    @(posedge clk);
    {flush, pf_byte, iob_rst} <= 3'(4 >> which);
    @(posedge clk);
    {flush, pf_byte, iob_rst} <= 3'h0;
    #1;
  endtask
  task automatic push(input int n);
    @(posedge clk);
    go     <= 1;
    n_push <= 4'(n);
    @(posedge clk);
    go     <= 0;
    sent   += n;
    #1;
  endtask
  task automatic settle;
    for (int i = 0; i < 30 && drq !== 1'b0; i++) @(posedge clk);
    if (drq !== 1'b0) n_mismatch++;
    @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1;
    acc(0, 0, 'hd5, 8'h00);
    acc(0, 0, 'he0, 8'h00);
    acc(0, 0, 'he1, 8'h02);
    acc(0, 0, 'hf0, 8'h02);
    acc(0, 0, 'hf1, 8'h01);
    acc(0, 0, 'hf2, 8'h24);
    acc(0, 0, 'hc3, 8'h01);
    `CHK(cg33, 1'b1)
    `CHK({cgf, cg133, cg66}, 3'h7)
    acc(0, 1, 'hd5, 8'hff);
    acc(0, 0, 'hd5, 8'h1b);
    `CHK(cg33, 1'b0)
    `CHK({cgf, cg133, cg66}, 3'h0)
    acc(0, 1, 'he1, 8'hff);
    acc(0, 0, 'he1, 8'h0f);
    acc(0, 1, 'hf1, 8'hfe);
    acc(0, 0, 'hf1, 8'h00);
    acc(0, 1, 'h20, 8'hff);
    acc(0, 0, 'h20, 8'hf1);
    acc(0, 1, 'h20, 8'h00);
    acc(0, 1, 'h21, 8'hc0);
    for (int k = 15; k < 17; k++) begin
      @(posedge clk);
      io_addr <= base + 32'(k);
      #1 `CHK(io_hit, 1'(k == 15))
    end
    foreach (offs[i]) begin
      acc(1, 0, base + 32'(offs[i]), 8'h00);
      acc(1, 1, base + 32'(offs[i]), 8'ha0 | 8'(offs[i]));
      acc(1, 0, base + 32'(offs[i]), 8'ha0 | 8'(offs[i]));
    end
    acc(1, 1, base + 32'h11, 8'h55);
    acc(1, 0, base + 32'h01, 8'h00);
    acc(1, 0, base + 32'h11, 8'h00);
    acc(1, 0, base + 32'h02, 8'h00);
    acc(1, 0, base + 32'h0a, 8'h00);
    @(posedge clk);
    {pset, sset} <= 16'h85ff;
    @(posedge clk);
    {pset, sset} <= 16'h0000;
    acc(1, 1, base + 32'h02, 8'h81);
    acc(1, 0, base + 32'h02, 8'h04);
    acc(1, 1, base + 32'h0a, 8'h0f);
    acc(1, 0, base + 32'h0a, 8'hf0);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      lv <= 5'(1 << i);
      acc(0, 0, 'hf0, 8'h02 | 8'(4 << i));
    end
    acc(0, 1, 'he0, 8'h02);
    acc(0, 1, 'he1, 8'h00);
    @(posedge clk);
    lv <= 5'h00;
    @(posedge clk);
    lv <= 5'h10;
    acc(0, 1, 'hc4, 8'h10);
    for (int i = 0; i < 2; i++) begin
      `CHK(pf_run, 1'b1)
      strobe(1);
    end
    `CHK(pf_run, 1'b0)
    acc(0, 1, 'hc4, 8'h00);
    `CHK(pf_run, 1'b1)
    @(posedge clk);
    lv   <= 5'h00;
    slow <= 1;
    for (int m = 0; m < 3; m++)
      for (int t = 0; t < 4; t++) begin
        acc(0, 1, 'hc3, m == 1 ? 8'h03 : 8'(t));
        acc(0, 1, 'hf2, m == 0 ? 8'h24 : m == 1 ? 8'h30 | 8'(t << 2) : 8'h3c);
        @(posedge clk);
        dir_m2d <= (m != 2);
        strobe(0);
        push(2 * t + 1);
        settle;
        `CHK(flush_now, 1'b0)
        push(1);
        settle;
        `CHK(flush_now, 1'b1)
      end
    @(posedge clk);
    slow <= 0;
    acc(0, 1, 'hf1, 8'h01);
    strobe(0);
    first = sent;
    push(9);
    for (int i = 0; i < 40 && wready !== 1'b0; i++) @(posedge clk);
    irq_req <= 1;
    repeat (3) @(posedge clk);
    #1 `CHK(wready, 1'b0)
    `CHK(drq, 1'b1)
    `CHK(irq, 1'b0)
    acc(0, 0, 'hf0, 8'h01);
    acc(0, 1, 'hf1, 8'h00);
    `CHK(irq, 1'b1)
    acc(0, 1, 'hf1, 8'h01);
    for (int k = 0; k < 9; k++) begin
      `CHK(rvalid, 1'b1)
      `CHK(rdata, 16'hd000 | 16'(8'(first + k)))
      @(posedge clk);
      rready <= 1;
      @(posedge clk);
      rready <= 0;
      #1;
    end
    `CHK(rvalid, 1'b0)
    acc(0, 0, 'hf0, 8'h82);
    @(posedge clk);
    irq_req <= 0;
    strobe(2);
    acc(0, 0, 'h21, 8'h00);
    acc(0, 0, 'h20, 8'h01);
    acc(0, 1, 'h21, 8'hc0);
    acc(0, 1, 'hf2, 8'h1c);
    strobe(2);
    acc(0, 0, 'h21, 8'hc0);
    acc(0, 0, 'hf2, 8'h1c);
    report_and_stop;
  end
endmodule
